/* File: rtl/bcc_pkg.sv */
package bcc_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [31:0] BCC_CTRL_ADDR = 32'h4000_5200;
  localparam logic [31:0] BCC_DRIFT_ADDR = 32'h4000_5204;
  localparam logic [31:0] BCC_SUB_ADDR = 32'h4000_5208;
  localparam logic [31:0] BCC_SEC_ADDR = 32'h4000_520C;
  localparam logic [31:0] BCC_MIN_ADDR = 32'h4000_5210;
  localparam logic [31:0] BCC_HOUR_ADDR = 32'h4000_5214;
  localparam logic [31:0] BCC_DAY_ADDR = 32'h4000_5218;
  localparam logic [31:0] BCC_WEEK_ADDR = 32'h4000_521C;
  localparam logic [31:0] BCC_MONTH_ADDR = 32'h4000_5220;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BCC_HOLD_BIT = 0;
  localparam int BCC_HOLD_STS_BIT = 1;
  localparam int BCC_FMT_BIT = 10;
  localparam int BCC_INTERVAL_BIT = 7;
  localparam int BCC_SIGN_BIT = 6;
  localparam int BCC_PM_BIT = 5;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [15:0] BCC_SUB_RST = 16'h0000;
  localparam logic [7:0] BCC_SEC_RST = 8'h00;
  localparam logic [7:0] BCC_MIN_RST = 8'h00;
  localparam logic [7:0] BCC_HOUR_RST = 8'h12;
  localparam logic [7:0] BCC_DAY_RST = 8'h01;
  localparam logic [2:0] BCC_WEEK_RST = 3'h0;
  localparam logic [7:0] BCC_MONTH_RST = 8'h00;
  localparam logic [7:0] BCC_DRIFT_RST = 8'h00;

  // ---------------------------------------------------------------
  // Counting limits
  // ---------------------------------------------------------------
  localparam logic [15:0] BCC_SUB_WRAP = 16'h7FFF;
  localparam logic [15:0] BCC_CORR_POINT = 16'h4000;
  localparam logic [1:0] BCC_HOLD_TICKS = 2'h2;
  localparam logic [7:0] BCC_SEC_MAX = 8'h59;
  localparam logic [7:0] BCC_HOUR24_MAX = 8'h23;
  localparam logic [7:0] BCC_HOUR12_LAST = 8'h31;
  localparam logic [7:0] BCC_DAY_MAX = 8'h31;
  localparam logic [7:0] BCC_WEEK_MAX = 8'h06;
  localparam logic [7:0] BCC_MONTH_MAX = 8'h12;

  // ---------------------------------------------------------------
  // Bus carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } bcc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bcc_apb_rsp_t;

endpackage

/* File: rtl/bcc_top.sv */
`timescale 1ns/1ns
// How it works
// - Twenty-second mode corrects at 00, 20, 40
// - Sixty-second mode corrects only at 00
// - Positive sign adds twice magnitude minus one
// - Negative sign subtracts twice inverted magnitude plus one
// - Upper five magnitude bits zero: no correction
// - Correction steps are even, 2 to 124
// - Sub-counter never exceeds 7FFFH after correction
// - Seconds write clears the sub-counter
// - Seconds count 0-59 on sub-counter overflow
// - Out-of-range BCD writes are discarded
// - Minutes count 0-59 on seconds wrap
// - Software write beats a simultaneous carry
// - Hours count in 24 or 12-hour coding
// - Twelve-hour codes: 12H midnight, 32H noon
// - Day wraps by month length and leap
// - Weekday follows days, 111 write ignored
// - Weekday never derived from month and day
// - Month counts 1-12, wraps after December
// - Sub-counter read-only, writes return an error; others allow bytes
// - Years divisible by four are leap years
// - Hold request freezes seconds upward, sub runs
// - Control bit 10 selects 12/24-hour format
module bcc_top (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic cal_clk_in,
  input wire logic [7:0] year_value_in,
  input wire bcc_pkg::bcc_apb_req_t apb_req_in,
  output bcc_pkg::bcc_apb_rsp_t apb_rsp_out,
  output logic year_carry_out
);
  import bcc_pkg::*;

  // ---------------------------------------------------------------
  // BCD helpers
  // ---------------------------------------------------------------
  function automatic logic bcd_ok(input logic [7:0] v, input logic [7:0] lo,
                                  input logic [7:0] hi);
    bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [4:0] bcd_to_bin(input logic [7:0] v);
    bcd_to_bin = ({3'h0, v[5:4]} * 5'h0A) + {1'b0, v[3:0]};
  endfunction

  function automatic logic [7:0] bin_to_bcd(input logic [4:0] b);
    bin_to_bcd = {4'(b / 5'h0A), 4'(b % 5'h0A)};
  endfunction

  function automatic logic [7:0] hour_inc(input logic [7:0] v, input logic fmt24);
    if (fmt24) begin
      hour_inc = (v == BCC_HOUR24_MAX) ? 8'h00 : bcd_inc(v);
    end else begin
      case (v)
        8'h11: hour_inc = 8'h32;
        8'h12: hour_inc = 8'h01;
        8'h31: hour_inc = 8'h12;
        8'h32: hour_inc = 8'h21;
        default: hour_inc = bcd_inc(v);
      endcase
    end
  endfunction

  function automatic logic [7:0] to_24h(input logic [7:0] v);
    logic [4:0] h;
    h = bcd_to_bin({3'h0, v[4:0]});
    if (h == 5'd12) begin
      h = 5'd0;
    end
    to_24h = bin_to_bcd(v[BCC_PM_BIT] ? h + 5'd12 : h);
  endfunction

  function automatic logic [7:0] to_12h(input logic [7:0] v);
    logic [4:0] h;
    logic pm;
    h = bcd_to_bin(v);
    pm = (h >= 5'd12);
    h = pm ? h - 5'd12 : h;
    if (h == 5'd0) begin
      h = 5'd12;
    end
    to_12h = bin_to_bcd(h) | {2'h0, pm, 5'h00};
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic cal_q_reg;
  logic [15:0] sub_reg;
  logic [15:0] sub_next;
  logic done_reg;
  logic pend_reg;
  logic [7:0] sec_reg;
  logic [7:0] sec_next;
  logic [7:0] min_reg;
  logic [7:0] min_next;
  logic [7:0] hour_reg;
  logic [7:0] hour_next;
  logic [7:0] day_reg;
  logic [7:0] day_next;
  logic [2:0] week_reg;
  logic [2:0] week_next;
  logic [7:0] month_reg;
  logic [7:0] month_next;
  logic [7:0] drift_reg;
  logic hold_reg;
  logic fmt_reg;
  logic [1:0] hold_cnt_reg;
  bcc_apb_rsp_t rsp_reg;
  bcc_apb_rsp_t rsp_next;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire setup = apb_req_in.psel && !apb_req_in.penable;
  wire wr = apb_req_in.psel && apb_req_in.penable && rsp_reg.pready && apb_req_in.pwrite;
  wire [31:0] addr = apb_req_in.paddr;
  wire [7:0] wdb = apb_req_in.pwdata[7:0];
  wire lane0 = apb_req_in.pstrb[0];
  wire sel_ctrl = (addr == BCC_CTRL_ADDR);
  wire sel_drift = (addr == BCC_DRIFT_ADDR);
  wire sel_sub = (addr == BCC_SUB_ADDR);
  wire sel_sec = (addr == BCC_SEC_ADDR);
  wire sel_min = (addr == BCC_MIN_ADDR);
  wire sel_hour = (addr == BCC_HOUR_ADDR);
  wire sel_day = (addr == BCC_DAY_ADDR);
  wire sel_week = (addr == BCC_WEEK_ADDR);
  wire sel_month = (addr == BCC_MONTH_ADDR);
  wire mapped = sel_ctrl | sel_drift | sel_sub | sel_sec | sel_min | sel_hour | sel_day
                | sel_week | sel_month;
  wire bad_acc = !mapped || (apb_req_in.pwrite && sel_sub);

  wire wr_sec = wr && sel_sec && lane0;
  wire hour_in_range = fmt_reg ? bcd_ok(wdb, 8'h00, BCC_HOUR24_MAX)
                       : (bcd_ok(wdb, 8'h01, 8'h12) || bcd_ok(wdb, 8'h21, 8'h32));
  wire wr_sec_ok = wr_sec && bcd_ok(wdb, 8'h00, BCC_SEC_MAX);
  wire wr_min_ok = wr && sel_min && lane0 && bcd_ok(wdb, 8'h00, BCC_SEC_MAX);
  wire wr_hour_ok = wr && sel_hour && lane0 && hour_in_range;
  wire wr_day_ok = wr && sel_day && lane0 && bcd_ok(wdb, 8'h01, BCC_DAY_MAX);
  wire wr_week_ok = wr && sel_week && lane0 && (wdb <= BCC_WEEK_MAX);
  wire wr_month_ok = wr && sel_month && lane0 && bcd_ok(wdb, 8'h01, BCC_MONTH_MAX);
  wire wr_drift = wr && sel_drift && lane0;
  wire wr_ctrl_lo = wr && sel_ctrl && lane0;
  wire wr_ctrl_hi = wr && sel_ctrl && apb_req_in.pstrb[1];
  wire fmt_change = wr_ctrl_hi && (apb_req_in.pwdata[BCC_FMT_BIT] != fmt_reg);

  // ---------------------------------------------------------------
  // Sub-counter and drift correction
  // ---------------------------------------------------------------
  wire tick = cal_clk_in && !cal_q_reg;
  wire sub_ovf = tick && (sub_reg >= BCC_SUB_WRAP);
  wire interval_sel = drift_reg[BCC_INTERVAL_BIT];
  wire corr_sign = drift_reg[BCC_SIGN_BIT];
  wire [5:0] corr_magnitude = drift_reg[5:0];
  wire sec_at_point = interval_sel ? (sec_reg == 8'h00)
                      : (sec_reg == 8'h00 || sec_reg == 8'h20 || sec_reg == 8'h40);
  wire corr_en = (corr_magnitude[5:1] != 5'h00);
  wire corr_fire = tick && (sub_reg == BCC_CORR_POINT) && !done_reg && sec_at_point
                   && corr_en && !wr_sec;
  wire [6:0] corr_half = corr_sign ? ({1'b0, ~corr_magnitude} + 7'h01)
                         : ({1'b0, corr_magnitude} - 7'h01);
  wire [15:0] corr_amt = {8'h00, corr_half, 1'b0};
  wire [15:0] sub_inc = sub_reg + 16'h0001;

  always_comb begin
    if (wr_sec) begin
      sub_next = BCC_SUB_RST;
    end else if (sub_ovf) begin
      sub_next = sub_reg - BCC_SUB_WRAP;
    end else if (corr_fire) begin
      sub_next = corr_sign ? sub_inc - corr_amt : sub_inc + corr_amt;
    end else if (tick) begin
      sub_next = sub_inc;
    end else begin
      sub_next = sub_reg;
    end
  end

  // ---------------------------------------------------------------
  // Carry chain
  // ---------------------------------------------------------------
  wire sec_step = (sub_ovf || pend_reg) && !hold_reg && !wr_sec;
  wire sec_wrap = sec_step && (sec_reg == BCC_SEC_MAX);
  wire min_step = sec_wrap && !wr_min_ok;
  wire min_wrap = min_step && (min_reg == BCC_SEC_MAX);
  wire hour_last = fmt_reg ? (hour_reg == BCC_HOUR24_MAX) : (hour_reg == BCC_HOUR12_LAST);
  wire hour_step = min_wrap && !wr_hour_ok;
  wire hour_wrap = hour_step && hour_last;
  wire leap = year_value_in[4] ? (year_value_in[3:0] == 4'h2 || year_value_in[3:0] == 4'h6)
              : (year_value_in[3:0] == 4'h0 || year_value_in[3:0] == 4'h4
                 || year_value_in[3:0] == 4'h8);
  wire short30 = (month_reg == 8'h04) || (month_reg == 8'h06) || (month_reg == 8'h09)
                 || (month_reg == 8'h11);
  wire [7:0] day_last = (month_reg == 8'h02) ? (leap ? 8'h29 : 8'h28)
                        : (short30 ? 8'h30 : BCC_DAY_MAX);
  wire day_step = hour_wrap && !wr_day_ok;
  wire day_wrap = day_step && (day_reg >= day_last);
  wire week_step = hour_wrap && !wr_week_ok;
  wire month_step = day_wrap && !wr_month_ok;
  wire month_wrap = month_step && (month_reg >= BCC_MONTH_MAX);

  assign sec_next = wr_sec_ok ? wdb : sec_wrap ? 8'h00 : sec_step ? bcd_inc(sec_reg) : sec_reg;
  assign min_next = wr_min_ok ? wdb : min_wrap ? 8'h00 : min_step ? bcd_inc(min_reg) : min_reg;
  assign hour_next = wr_hour_ok ? wdb
                     : fmt_change ? (fmt_reg ? to_12h(hour_reg) : to_24h(hour_reg))
                     : hour_step ? hour_inc(hour_reg, fmt_reg) : hour_reg;
  assign day_next = wr_day_ok ? wdb : day_wrap ? 8'h01 : day_step ? bcd_inc(day_reg) : day_reg;
  assign week_next = wr_week_ok ? wdb[2:0]
                     : week_step ? ((week_reg == BCC_WEEK_MAX[2:0]) ? 3'h0 : week_reg + 3'h1)
                     : week_reg;
  assign month_next = wr_month_ok ? wdb : month_wrap ? 8'h01
                      : month_step ? bcd_inc(month_reg) : month_reg;

  // ---------------------------------------------------------------
  // Read mux and bus response
  // ---------------------------------------------------------------
  wire hold_sts = hold_reg && (hold_cnt_reg == BCC_HOLD_TICKS);
  wire [31:0] ctrl_rd = {21'h0, fmt_reg, 8'h00, hold_sts, hold_reg};
  wire [31:0] rd_data = sel_ctrl ? ctrl_rd
                        : sel_drift ? {24'h0, drift_reg}
                        : sel_sub ? {16'h0, sub_reg}
                        : sel_sec ? {24'h0, sec_reg}
                        : sel_min ? {24'h0, min_reg}
                        : sel_hour ? {24'h0, hour_reg}
                        : sel_day ? {24'h0, day_reg}
                        : sel_week ? {29'h0, week_reg}
                        : sel_month ? {24'h0, month_reg} : 32'h0000_0000;

  always_comb begin
    rsp_next.pready = setup;
    rsp_next.pslverr = setup && bad_acc;
    rsp_next.prdata = (setup && !apb_req_in.pwrite) ? rd_data : 32'h0000_0000;
  end

  assign apb_rsp_out = rsp_reg;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cal_q_reg <= 1'b0;
      sub_reg <= BCC_SUB_RST;
      done_reg <= 1'b0;
      pend_reg <= 1'b0;
      sec_reg <= BCC_SEC_RST;
      min_reg <= BCC_MIN_RST;
      hour_reg <= BCC_HOUR_RST;
      day_reg <= BCC_DAY_RST;
      week_reg <= BCC_WEEK_RST;
      month_reg <= BCC_MONTH_RST;
      year_carry_out <= 1'b0;
    end else begin
      cal_q_reg <= cal_clk_in;
      sub_reg <= sub_next;
      done_reg <= corr_fire || (done_reg && !sub_ovf && !wr_sec);
      pend_reg <= (sub_ovf && hold_reg && !wr_sec) || (pend_reg && hold_reg && !wr_sec);
      sec_reg <= sec_next;
      min_reg <= min_next;
      hour_reg <= hour_next;
      day_reg <= day_next;
      week_reg <= week_next;
      month_reg <= month_next;
      year_carry_out <= month_wrap;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      drift_reg <= BCC_DRIFT_RST;
      hold_reg <= 1'b0;
      fmt_reg <= 1'b0;
      hold_cnt_reg <= 2'h0;
      rsp_reg <= '0;
    end else begin
      if (wr_drift) begin
        drift_reg <= wdb;
      end
      if (wr_ctrl_lo) begin
        hold_reg <= apb_req_in.pwdata[BCC_HOLD_BIT];
      end
      if (wr_ctrl_hi) begin
        fmt_reg <= apb_req_in.pwdata[BCC_FMT_BIT];
      end
      if (!hold_reg) begin
        hold_cnt_reg <= 2'h0;
      end else if (tick && hold_cnt_reg != BCC_HOLD_TICKS) begin
        hold_cnt_reg <= hold_cnt_reg + 2'h1;
      end
      rsp_reg <= rsp_next;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_sec_write;
    wr && sel_sec && lane0;
  endsequence

  sequence s_held_two;
    hold_reg && !wr_sec && !wr_sec_ok ##1 hold_reg && !wr_sec;
  endsequence

  a_corr_point: assert property (corr_fire |-> sec_at_point && corr_en
    && (interval_sel ? sec_reg == 8'h00 : sec_reg[3:0] == 4'h0 && !sec_reg[4]))
    else $error("correction outside a correction second");
  a_corr_sixty: assert property (interval_sel && sec_reg != 8'h00 |-> !corr_fire)
    else $error("sixty-second mode corrected away from 00");
  a_corr_amount: assert property (corr_fire ##0 !sub_ovf |=>
    sub_reg == $past(sub_reg) + 16'h1 + {9'h000, $past(corr_magnitude), 1'b0}
    - ($past(corr_sign) ? 16'h0080 : 16'h0002))
    else $error("correction amount wrong");
  a_corr_none: assert property (tick && !corr_en && !wr_sec && sub_reg < BCC_SUB_WRAP
    |=> sub_reg == $past(sub_reg) + 16'h1)
    else $error("sub-counter moved by other than one");
  a_sub_clear: assert property (s_sec_write |=> sub_reg == 16'h0000)
    else $error("seconds write left sub-counter nonzero");
  a_sec_range: assert property (sec_reg[3:0] <= 4'h9 && sec_reg <= BCC_SEC_MAX)
    else $error("seconds out of range");
  a_write_wins: assert property (wr_min_ok && sec_wrap |=>
    min_reg == $past(apb_req_in.pwdata[7:0]))
    else $error("carry beat a minute write");
  a_noon_code: assert property (hour_step && !fmt_reg && hour_reg == 8'h11 && !fmt_change
    |=> hour_reg == 8'h32)
    else $error("noon not coded 32H");
  a_week_ignore: assert property (wr && sel_week && lane0 && wdb[2:0] == 3'h7
    && wdb[7:3] == 5'h00 && !week_step |=> $stable(week_reg))
    else $error("weekday took an illegal write");
  a_hold_freeze: assert property (s_held_two |-> $stable(sec_reg))
    else $error("seconds moved while held");
  a_leap_feb: assert property (day_step && month_reg == 8'h02 && day_reg == 8'h28 && leap
    |=> day_reg == 8'h29)
    else $error("leap February wrapped early");

endmodule // bcc_top

/* File: bench/tb_bcd_calendar_counter_chain.sv */
`timescale 1ns/1ns
module tb_bcd_calendar_counter_chain;
  import bcc_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic mclk_in;
  logic rst_n_in;
  logic cal_clk_in;
  logic [7:0] year_value_in;
  bcc_apb_req_t apb_req;
  bcc_apb_rsp_t apb_rsp;
  logic year_carry;
  int num_errors;
  int checks_done;
  int carry_seen;
  logic [31:0] rst_addr [8] = '{BCC_SUB_ADDR, BCC_SEC_ADDR, BCC_MIN_ADDR, BCC_HOUR_ADDR,
    BCC_DAY_ADDR, BCC_WEEK_ADDR, BCC_MONTH_ADDR, BCC_DRIFT_ADDR};
  logic [31:0] rst_exp [8] = '{32'h0, 32'h0, 32'h0, 32'h12, 32'h1, 32'h0, 32'h0, 32'h0};
  // Write value and expected read-back, refused values leave the old one
  logic [31:0] rng_addr [17] = '{BCC_SEC_ADDR, BCC_SEC_ADDR, BCC_SEC_ADDR, BCC_MIN_ADDR,
    BCC_MIN_ADDR, BCC_HOUR_ADDR, BCC_HOUR_ADDR, BCC_HOUR_ADDR, BCC_HOUR_ADDR, BCC_DAY_ADDR,
    BCC_DAY_ADDR, BCC_DAY_ADDR, BCC_WEEK_ADDR, BCC_WEEK_ADDR, BCC_MONTH_ADDR,
    BCC_MONTH_ADDR, BCC_MONTH_ADDR};
  logic [31:0] rng_data [17] = '{32'h5A, 32'h60, 32'h59, 32'h6A, 32'h45, 32'h13, 32'h00,
    32'h20, 32'h32, 32'h00, 32'h32, 32'h31, 32'h07, 32'h06, 32'h13, 32'h00, 32'h12};
  logic [31:0] rng_exp [17] = '{32'h00, 32'h00, 32'h59, 32'h00, 32'h45, 32'h12, 32'h12,
    32'h12, 32'h32, 32'h01, 32'h01, 32'h31, 32'h00, 32'h06, 32'h00, 32'h00, 32'h12};

  bcc_top bcc_top_i (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .cal_clk_in(cal_clk_in),
    .year_value_in(year_value_in),
    .apb_req_in(apb_req),
    .apb_rsp_out(apb_rsp),
    .year_carry_out(year_carry)
  );

  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    if (year_carry === 1'b1) carry_seen++;
  end

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t data got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr_en, input logic [31:0] addr, input logic [31:0] data,
                     output logic [31:0] rd_data, output logic err);
    int n;
    n = 0;
    @(posedge mclk_in);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr_en;
    apb_req.paddr <= addr;
    apb_req.pwdata <= data;
    apb_req.pstrb <= 4'hF;
    @(posedge mclk_in);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      $display("ERROR t=%0t no ready on bus", $time);
    end
    rd_data = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] data, input logic exp_err);
    logic [31:0] d;
    logic e;
    apb(1'b1, addr, data, d, e);
    chk1(e, exp_err);
  endtask

  task automatic rd(input logic [31:0] addr, input logic [31:0] exp, input logic exp_err);
    logic [31:0] d;
    logic e;
    apb(1'b0, addr, 32'h0, d, e);
    chk32(d, exp);
    chk1(e, exp_err);
  endtask

  // One calendar tick is one high and one low mclk cycle
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge mclk_in);
      cal_clk_in <= 1'b1;
      @(posedge mclk_in);
      cal_clk_in <= 1'b0;
    end
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    rst_n_in = 1'b0;
    cal_clk_in = 1'b0;
    year_value_in = 8'h01;
    apb_req = '0;
    num_errors = 0;
    checks_done = 0;
    carry_seen = 0;
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 8; i++) rd(rst_addr[i], rst_exp[i], 1'b0);
    rd(32'h4000_5228, 32'h0, 1'b1);
    wr(32'h4000_5228, 32'h1, 1'b1);
    wr(BCC_SUB_ADDR, 32'h55, 1'b1);
    for (int i = 0; i < 17; i++) begin
      wr(rng_addr[i], rng_data[i], 1'b0);
      rd(rng_addr[i], rng_exp[i], 1'b0);
    end
    // Format switch converts the stored hour
    wr(BCC_CTRL_ADDR, 32'h400, 1'b0);
    rd(BCC_CTRL_ADDR, 32'h400, 1'b0);
    rd(BCC_HOUR_ADDR, 32'h12, 1'b0);
    wr(BCC_HOUR_ADDR, 32'h24, 1'b0);
    rd(BCC_HOUR_ADDR, 32'h12, 1'b0);
    wr(BCC_HOUR_ADDR, 32'h23, 1'b0);
    wr(BCC_CTRL_ADDR, 32'h000, 1'b0);
    rd(BCC_HOUR_ADDR, 32'h31, 1'b0);
    // Hold keeps the sub-counter running, status follows after two ticks
    wr(BCC_CTRL_ADDR, 32'h1, 1'b0);
    rd(BCC_CTRL_ADDR, 32'h1, 1'b0);
    ticks(5);
    rd(BCC_CTRL_ADDR, 32'h3, 1'b0);
    rd(BCC_SUB_ADDR, 32'h5, 1'b0);
    wr(BCC_CTRL_ADDR, 32'h0, 1'b0);
    // Seconds write clears the sub-counter
    wr(BCC_SEC_ADDR, 32'h10, 1'b0);
    rd(BCC_SUB_ADDR, 32'h0, 1'b0);
    // Positive correction at second 40 in twenty-second mode: +(44-1)*2
    wr(BCC_DRIFT_ADDR, 32'h2C, 1'b0);
    rd(BCC_DRIFT_ADDR, 32'h2C, 1'b0);
    wr(BCC_SEC_ADDR, 32'h40, 1'b0);
    ticks(32'h4001);
    rd(BCC_SUB_ADDR, 32'h4057, 1'b0);
    rd(BCC_SEC_ADDR, 32'h40, 1'b0);
    // Full ripple from 11 p.m. on December 31st, second 59 is no correction point
    wr(BCC_MIN_ADDR, 32'h59, 1'b0);
    wr(BCC_DAY_ADDR, 32'h31, 1'b0);
    wr(BCC_SEC_ADDR, 32'h59, 1'b0);
    wr(BCC_DRIFT_ADDR, 32'hBC, 1'b0);
    chk32(32'(carry_seen), 32'h0);
    ticks(32'h4001);
    rd(BCC_SUB_ADDR, 32'h4001, 1'b0);
    ticks(32'h3FFF);
    rd(BCC_SUB_ADDR, 32'h0, 1'b0);
    rd(BCC_SEC_ADDR, 32'h00, 1'b0);
    rd(BCC_MIN_ADDR, 32'h00, 1'b0);
    rd(BCC_HOUR_ADDR, 32'h12, 1'b0);
    rd(BCC_DAY_ADDR, 32'h01, 1'b0);
    rd(BCC_WEEK_ADDR, 32'h00, 1'b0);
    rd(BCC_MONTH_ADDR, 32'h01, 1'b0);
    chk32(32'(carry_seen), 32'h1);
    end_sim();
  end

  initial begin
    repeat (105000) @(posedge mclk_in);
    num_errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    end_sim();
  end

endmodule // tb_bcd_calendar_counter_chain
